// ===== pkg/tms_pkg.sv
/*
  constants, mode type and register map of the timing mode supervisor.
  assumes a 200 MHz system clock and a wishbone classic master with 32-bit data.
*/
// How it works
// RQ1: no mode select asserted gives free-running mode
// RQ2: selecting either reference starts fast acquisition automatically
// RQ3: fast acquisition slews under 2.9 ppm/s, slow filter by 600 s
// RQ4: locked operation re-enters fast acquisition when phase error exceeds 20 us
// RQ5: holdover valid 701 s after selection, average updated every 8 s
// RQ6: long-term holdover is a moving average over 1049 s of history
// RQ7: averaging is frozen during reference loss and fast acquisition
// RQ8: holdover values are delayed at least 32 s before use
// RQ9: a low level on the reset input fully resets the block
// RQ10: tri-state input floats all outputs while logic keeps running
// RQ11: output steering follows reference when locked, fixed in holdover or free run
// RQ12: the 8 kHz output divides down the primary synchronised output
// RQ13: loss-of-reference flag rises when the active reference disappears
// RQ14: frequency limit alarm when output is 15 ppm or more off free run
// RQ15: phase build-out flag on steps above 3.4 us in any 0.1 s window
// RQ16: mode alarm in holdover, free run, fast acquisition or long build-out
// RQ17: holdover-good only after about 700 s averaging on a new reference
// RQ18: holdover before first holdover-good uses free-run frequency, else last average
// RQ19: host selects mode with two pins, high then low, both default low
// RQ20: status pins report mode: 00 free, 01 ref one, 10 ref two, 11 holdover
// RQ21: mode alarm is one for alarm and zero for normal operation
// RQ22: all second timers derive from one internal one-second tick
// RQ23: a reference change clears holdover-good and restarts averaging timers
package tms_pkg;
  // clock and time bases
  localparam longint CLK_PERIOD_PS = 5000;
  localparam longint TICK_PERIOD_MS = 1000;
  localparam longint LOR_TIME_US = 250;
  localparam longint PBO_WINDOW_MS = 100;
  localparam longint PBO_ALARM_MS = 400;
  localparam int TICK_CYCLES = int'(TICK_PERIOD_MS * 64'd1000000000 / CLK_PERIOD_PS);
  localparam int LOR_CYCLES = int'(LOR_TIME_US * 64'd1000000 / CLK_PERIOD_PS);
  localparam int PBO_WINDOW_CYCLES = int'(PBO_WINDOW_MS * 64'd1000000000 / CLK_PERIOD_PS);
  localparam int PBO_ALARM_CYCLES =
    int'((PBO_ALARM_MS * 64'd1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) + 1;
  // second-scale figures
  localparam logic [10:0] FILTER_SWITCH_S = 11'd600;
  localparam logic [10:0] HO_VALID_S = 11'd701;
  localparam int HO_UPDATE_S = 8;
  localparam int HO_HISTORY_S = 1049;
  localparam int HO_DELAY_S = 32;
  localparam int HO_SAMPLES = HO_HISTORY_S / HO_UPDATE_S;
  localparam int HO_DELAY_STAGES = (HO_DELAY_S + HO_UPDATE_S - 1) / HO_UPDATE_S;
  localparam logic [10:0] SEC_MAX = 11'h7ff;
  // phase and frequency limits, ns and ppb
  localparam logic [31:0] PHASE_REACQ_NS = 32'd20000;
  localparam logic [31:0] PBO_STEP_NS = 32'd3400;
  localparam logic [31:0] RFL_LIMIT_PPB = 32'd15000;
  localparam logic signed [31:0] SLEW_PPB_PER_S = 32'sd2900;
  localparam int SLOW_FILTER_SHIFT = 8;
  // register map, byte addresses
  localparam logic [7:0] CTRL_OFFS = 8'h00;
  localparam logic [7:0] STATUS_OFFS = 8'h04;
  localparam logic [7:0] HOLD_OFFS = 8'h08;
  localparam logic [7:0] AVG_OFFS = 8'h0c;
  localparam logic [7:0] SEC_OFFS = 8'h10;
  localparam logic [15:0] DIV_RATIO_RST = 16'h00c1;
  // status field positions
  localparam int ST_MODE_LSB = 0;
  localparam int ST_FAST_BIT = 2;
  localparam int ST_SLOW_BIT = 3;
  localparam int ST_LOR_BIT = 4;
  localparam int ST_RFL_BIT = 5;
  localparam int ST_PBO_BIT = 6;
  localparam int ST_ALARM_BIT = 7;
  localparam int ST_HOGOOD_BIT = 8;
  localparam int ST_TRI_BIT = 9;

  typedef enum logic [1:0] {TMS_FREE, TMS_REF1, TMS_REF2, TMS_HOLD} tms_mode_e;
endpackage : tms_pkg

// ===== logic/tms_supervisor.sv
/*
  timing mode supervisor: mode selection, fast acquisition, holdover averaging,
  alarm flags, 8 kHz divider and a wishbone classic register slave.
  assumes the loop logic supplies phase error, measured frequency offset and a
  one-cycle pulse per primary output period, all on clk.
*/
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/10ps
module tms_supervisor import tms_pkg::*; #(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int LOR_CYC = LOR_CYCLES,
  parameter int PBO_WIN_CYC = PBO_WINDOW_CYCLES,
  parameter int PBO_ALARM_CYC = PBO_ALARM_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic modeSelectLow,
  input wire logic modeSelectHigh,
  input wire logic triState,
  input wire logic refIn1,
  input wire logic refIn2,
  input wire logic signed [31:0] phaseErrNs,
  input wire logic signed [31:0] freqMeasPpb,
  input wire logic syncTick,
  output logic [1:0] modeStatus,
  output logic referenceLostFlag,
  output logic phaseBuildoutFlag,
  output logic frequencyLimitAlarm,
  output logic holdoverGood,
  output logic modeAlarm,
  output logic out8k,
  output logic signed [31:0] freqSteerPpb,
  output logic outEnN
);
  typedef struct packed {
    logic [1:0] selS1, selS2, selS3, selF;
    logic [2:0] tsS;
    logic tsF;
    logic [1:0] refS1, refS2, refS3, refF, refPrev;
    tms_mode_e mode;
    logic [31:0] tickCnt;
    logic tick;
    logic [10:0] secCnt;
    logic [10:0] fastCnt;
    logic fastAcq;
    logic [31:0] lorCnt;
    logic reference_lost_flag;
    logic signed [31:0] steer;
    logic [2:0] avgSub;
    logic [7:0] sampCount;
    logic [7:0] wrPtr;
    logic signed [39:0] sum;
    logic signed [31:0] avg;
    logic [HO_DELAY_STAGES-1:0][31:0] dly;
    logic hoGood, hoEver;
    logic signed [31:0] holdFreq;
    logic [31:0] pboWinCnt;
    logic signed [31:0] pboBase;
    logic pboHit, phase_buildout_flag;
    logic [31:0] pboLongCnt;
    logic pboLong;
    logic [15:0] divRatio, divCnt;
    logic [1:0] statusOut;
    logic lorOut, pboOut, rflOut, hoGoodOut, alarmOut, out8kOut, outEnN;
    logic signed [31:0] steerOut;
    logic ack;
    logic [31:0] rdat;
  } tms_state_s;

  tms_state_s st_reg, st_next;
  logic signed [31:0] hist [0:HO_SAMPLES-1];
  tms_mode_e newMode;
  logic nRef, isRef, newRef, refEdge, sample;
  logic signed [31:0] diff, step, oldest, phaseDelta;
  logic signed [39:0] sumNew;
  logic [7:0] countNew;
  logic [15:0] halfRatio;
  logic [31:0] statusWord;

  function automatic logic [31:0] absVal(input logic signed [31:0] v);
    absVal = v[31] ? 32'(-v) : 32'(v);
  endfunction : absVal

  function automatic logic isRefMode(input tms_mode_e m);
    isRefMode = (m == TMS_REF1) || (m == TMS_REF2);
  endfunction : isRefMode

  // history of steering samples; memory needs no reset
  always_ff @(posedge clk) begin
    if (sample) begin
      hist[st_reg.wrPtr] <= st_reg.steer; // RQ6
    end
  end

  // all next-state logic
  always_comb begin
    st_next = st_reg;
    newMode = TMS_FREE;
    diff = '0;
    step = '0;
    sumNew = st_reg.sum;
    countNew = st_reg.sampCount;
    oldest = hist[st_reg.wrPtr];
    phaseDelta = phaseErrNs - st_reg.pboBase;
    halfRatio = st_reg.divRatio >> 1;
    statusWord = '0;
    sample = 1'b0;
    // pins from outside pass three stages; a change counts when stages two and three agree
    st_next.selS1 = {modeSelectHigh, modeSelectLow}; // RQ19
    st_next.selS2 = st_reg.selS1;
    st_next.selS3 = st_reg.selS2;
    if (st_reg.selS2 == st_reg.selS3) begin
      st_next.selF = st_reg.selS3;
    end
    st_next.tsS = {st_reg.tsS[1:0], triState};
    if (st_reg.tsS[1] == st_reg.tsS[2]) begin
      st_next.tsF = st_reg.tsS[2];
    end
    st_next.refS1 = {refIn2, refIn1};
    st_next.refS2 = st_reg.refS1;
    st_next.refS3 = st_reg.refS2;
    for (int i = 0; i < 2; i++) begin
      if (st_reg.refS2[i] == st_reg.refS3[i]) begin
        st_next.refF[i] = st_reg.refS3[i];
      end
    end
    st_next.refPrev = st_reg.refF;
    // one-second tick for every second-scale timer
    if (st_reg.tickCnt == 32'(TICK_CYC - 1)) begin // RQ22
      st_next.tickCnt = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.tickCnt = st_reg.tickCnt + 32'd1;
      st_next.tick = 1'b0;
    end
    // mode decode from the filtered select pins
    case (st_reg.selF)
      2'h1: newMode = TMS_REF1;
      2'h2: newMode = TMS_REF2;
      2'h3: newMode = TMS_HOLD;
      default: newMode = TMS_FREE; // RQ1
    endcase
    st_next.mode = newMode;
    nRef = isRefMode(newMode);
    isRef = isRefMode(st_reg.mode);
    newRef = nRef && (newMode != st_reg.mode);
    refEdge = (st_reg.mode == TMS_REF2) ? (st_reg.refF[1] & ~st_reg.refPrev[1])
                                        : (st_reg.refF[0] & ~st_reg.refPrev[0]);
    // loss of the active reference: no edge within the timeout
    if (!isRef || refEdge) begin
      st_next.lorCnt = '0;
      st_next.reference_lost_flag = 1'b0;
    end else if (st_reg.lorCnt >= 32'(LOR_CYC - 1)) begin
      st_next.reference_lost_flag = 1'b1; // RQ13
    end else begin
      st_next.lorCnt = st_reg.lorCnt + 32'd1;
    end
    // seconds since selection and fast acquisition sequencing
    if (isRef && st_reg.tick && st_reg.secCnt != SEC_MAX) begin
      st_next.secCnt = st_reg.secCnt + 11'd1;
    end
    if (!isRef) begin
      st_next.fastAcq = 1'b0;
    end else if (st_reg.fastAcq) begin
      if (st_reg.tick) begin
        if (st_reg.fastCnt == FILTER_SWITCH_S - 11'd1) begin
          st_next.fastAcq = 1'b0; // RQ3
        end else begin
          st_next.fastCnt = st_reg.fastCnt + 11'd1;
        end
      end
    end else if (!st_reg.reference_lost_flag && absVal(phaseErrNs) > PHASE_REACQ_NS) begin
      st_next.fastAcq = 1'b1; // RQ4
      st_next.fastCnt = '0;
    end
    // steering word: slew-limited while acquiring, slow filter afterwards
    diff = freqMeasPpb - st_reg.steer;
    if (!isRef) begin
      st_next.steer = (st_reg.mode == TMS_HOLD) ? st_reg.holdFreq : '0; // RQ11
    end else if (st_reg.tick && !st_reg.reference_lost_flag) begin
      if (st_reg.fastAcq) begin
        step = (diff > SLEW_PPB_PER_S) ? SLEW_PPB_PER_S :
               (diff < -SLEW_PPB_PER_S) ? -SLEW_PPB_PER_S : diff; // RQ3
      end else begin
        step = diff >>> SLOW_FILTER_SHIFT;
      end
      st_next.steer = st_reg.steer + step; // RQ11
    end
    // holdover averaging every eight seconds, frozen on loss or acquisition
    if (isRef && st_reg.tick && !st_reg.reference_lost_flag && !st_reg.fastAcq) begin // RQ7
      if (st_reg.avgSub == 3'(HO_UPDATE_S - 1)) begin
        st_next.avgSub = '0;
        sample = 1'b1; // RQ5
      end else begin
        st_next.avgSub = st_reg.avgSub + 3'd1;
      end
    end
    if (sample) begin
      if (st_reg.sampCount == 8'(HO_SAMPLES)) begin
        sumNew = st_reg.sum + 40'(st_reg.steer) - 40'(oldest); // RQ6
      end else begin
        sumNew = st_reg.sum + 40'(st_reg.steer);
        countNew = st_reg.sampCount + 8'd1;
      end
      st_next.sum = sumNew;
      st_next.sampCount = countNew;
      st_next.wrPtr = (st_reg.wrPtr == 8'(HO_SAMPLES - 1)) ? 8'd0 : st_reg.wrPtr + 8'd1;
      st_next.avg = 32'(sumNew / $signed({32'd0, countNew}));
      // values pass a delay line of update steps before holdover may use them
      st_next.dly = {st_reg.dly[HO_DELAY_STAGES-2:0], st_reg.avg}; // RQ8
    end
    if (isRef && st_reg.secCnt >= HO_VALID_S && st_reg.sampCount != 8'd0) begin
      st_next.hoGood = 1'b1; // RQ17
      st_next.hoEver = 1'b1;
    end
    // holdover entry picks free run until a first good average exists
    if (newMode == TMS_HOLD && st_reg.mode != TMS_HOLD) begin
      st_next.holdFreq = st_reg.hoEver ? st_reg.dly[HO_DELAY_STAGES-1] : '0; // RQ18
    end
    // phase build-out: step against the window's starting phase
    if (!isRef) begin
      st_next.pboWinCnt = '0;
      st_next.pboBase = phaseErrNs;
      st_next.pboHit = 1'b0;
      st_next.phase_buildout_flag = 1'b0;
    end else if (st_reg.pboWinCnt == 32'(PBO_WIN_CYC - 1)) begin
      st_next.pboWinCnt = '0;
      st_next.pboBase = phaseErrNs;
      st_next.phase_buildout_flag = st_reg.pboHit; // RQ15
      st_next.pboHit = 1'b0;
    end else begin
      st_next.pboWinCnt = st_reg.pboWinCnt + 32'd1;
      if (absVal(phaseDelta) > PBO_STEP_NS) begin
        st_next.pboHit = 1'b1;
        st_next.phase_buildout_flag = 1'b1; // RQ15
      end
    end
    if (!st_reg.phase_buildout_flag) begin
      st_next.pboLongCnt = '0;
    end else if (st_reg.pboLongCnt != 32'(PBO_ALARM_CYC)) begin
      st_next.pboLongCnt = st_reg.pboLongCnt + 32'd1;
    end
    st_next.pboLong = st_reg.phase_buildout_flag && st_reg.pboLongCnt >= 32'(PBO_ALARM_CYC - 1);
    // a new reference restarts every averaging timer
    if (newRef) begin // RQ23
      st_next.secCnt = '0;
      st_next.fastAcq = 1'b1; // RQ2
      st_next.fastCnt = '0;
      st_next.hoGood = 1'b0;
      st_next.avgSub = '0;
      st_next.sampCount = '0;
      st_next.wrPtr = '0;
      st_next.sum = '0;
    end
    // 8 kHz divider running on the primary output period pulse
    if (syncTick) begin
      if (st_reg.divCnt + 16'd1 >= halfRatio) begin
        st_next.divCnt = '0;
        st_next.out8kOut = ~st_reg.out8kOut; // RQ12
      end else begin
        st_next.divCnt = st_reg.divCnt + 16'd1;
      end
    end
    // pin outputs, registered from next state; outEnN from the current filtered tri-state
    st_next.statusOut = newMode; // RQ20
    st_next.lorOut = st_next.reference_lost_flag;
    st_next.pboOut = st_next.phase_buildout_flag;
    st_next.rflOut = absVal(st_next.steer) >= RFL_LIMIT_PPB; // RQ14
    st_next.hoGoodOut = st_next.hoGood;
    st_next.alarmOut = !nRef || st_next.fastAcq || st_next.pboLong; // RQ16 RQ21
    st_next.steerOut = st_next.steer;
    st_next.outEnN = st_reg.tsF; // RQ10
    // wishbone slave: ack one cycle after the strobe, dropped the next cycle
    statusWord[ST_MODE_LSB +: 2] = st_reg.mode;
    statusWord[ST_FAST_BIT] = st_reg.fastAcq;
    statusWord[ST_SLOW_BIT] = isRef && !st_reg.fastAcq;
    statusWord[ST_LOR_BIT] = st_reg.reference_lost_flag;
    statusWord[ST_RFL_BIT] = st_reg.rflOut;
    statusWord[ST_PBO_BIT] = st_reg.phase_buildout_flag;
    statusWord[ST_ALARM_BIT] = st_reg.alarmOut;
    statusWord[ST_HOGOOD_BIT] = st_reg.hoGood;
    statusWord[ST_TRI_BIT] = st_reg.tsF;
    st_next.ack = wb_cyc_i && wb_stb_i && !st_reg.ack;
    if (wb_cyc_i && wb_stb_i && !st_reg.ack) begin
      case (wb_adr_i)
        CTRL_OFFS: st_next.rdat = {16'h0000, st_reg.divRatio};
        STATUS_OFFS: st_next.rdat = statusWord;
        HOLD_OFFS: st_next.rdat = st_reg.holdFreq;
        AVG_OFFS: st_next.rdat = st_reg.avg;
        SEC_OFFS: st_next.rdat = {21'h000000, st_reg.secCnt};
        default: st_next.rdat = '0;
      endcase
      if (wb_we_i && wb_adr_i == CTRL_OFFS) begin
        if (wb_sel_i[0]) st_next.divRatio[7:0] = wb_dat_i[7:0];
        if (wb_sel_i[1]) st_next.divRatio[15:8] = wb_dat_i[15:8];
      end
    end
  end

  // one register for all state but the history memory; asynchronous reset loads constants only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin // RQ9
      st_reg <= '0;
      st_reg.divRatio <= DIV_RATIO_RST;
      st_reg.alarmOut <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_dat_o = st_reg.rdat;
  assign wb_ack_o = st_reg.ack;
  assign modeStatus = st_reg.statusOut;
  assign referenceLostFlag = st_reg.lorOut;
  assign phaseBuildoutFlag = st_reg.pboOut;
  assign frequencyLimitAlarm = st_reg.rflOut;
  assign holdoverGood = st_reg.hoGoodOut;
  assign modeAlarm = st_reg.alarmOut;
  assign out8k = st_reg.out8kOut;
  assign freqSteerPpb = st_reg.steerOut;
  assign outEnN = st_reg.outEnN;

  // checks on the design's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_free_sel;
    (st_reg.selF == 2'h0) |=> (st_reg.mode == TMS_FREE);
  endproperty
  a_free_sel: assert property (p_free_sel) else $error("free run not entered"); // RQ1

  property p_fast_on_sel;
    (isRefMode(st_reg.mode) && st_reg.mode != $past(st_reg.mode)) |-> st_reg.fastAcq;
  endproperty
  a_fast_on_sel: assert property (p_fast_on_sel) else $error("no fast acquisition"); // RQ2

  property p_fast_bound;
    st_reg.fastAcq |-> st_reg.fastCnt < FILTER_SWITCH_S;
  endproperty
  a_fast_bound: assert property (p_fast_bound) else $error("slow filter late"); // RQ3

  property p_hogood_time;
    $rose(st_reg.hoGood) |-> (st_reg.secCnt > HO_VALID_S - 11'd1);
  endproperty
  a_hogood_time: assert property (p_hogood_time) else $error("holdover good early"); // RQ5

  property p_hold_free;
    (st_reg.mode != TMS_HOLD && st_next.mode == TMS_HOLD && !st_reg.hoEver)
      |=> (st_reg.holdFreq == 32'sd0) [*2];
  endproperty
  a_hold_free: assert property (p_hold_free) else $error("holdover not free run"); // RQ18

  property p_freeze;
    (st_reg.reference_lost_flag || st_reg.fastAcq) |-> !sample;
  endproperty
  a_freeze: assert property (p_freeze) else $error("average updated while frozen"); // RQ7

  property p_rfl;
    (absVal(st_reg.steer) >= RFL_LIMIT_PPB) |-> frequencyLimitAlarm;
  endproperty
  a_rfl: assert property (p_rfl) else $error("frequency limit alarm missing"); // RQ14

  property p_alarm;
    (st_reg.mode == TMS_FREE || st_reg.mode == TMS_HOLD) |-> modeAlarm;
  endproperty
  a_alarm: assert property (p_alarm) else $error("mode alarm missing"); // RQ16

  property p_status;
    modeStatus == st_reg.mode;
  endproperty
  a_status: assert property (p_status) else $error("status pins wrong"); // RQ20

  property p_tri;
    $rose(st_reg.tsF) |=> outEnN;
  endproperty
  a_tri: assert property (p_tri) else $error("outputs not floated"); // RQ10

  property p_restart;
    (isRefMode(st_reg.mode) && st_reg.mode != $past(st_reg.mode))
      |-> (st_reg.secCnt == 11'd0 && !st_reg.hoGood);
  endproperty
  a_restart: assert property (p_restart) else $error("timers not restarted"); // RQ23

  property p_wb_ack;
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("bus answer timing wrong");

  c_hold_entry: cover property (st_reg.mode == TMS_REF1 ##1 st_reg.mode == TMS_HOLD);
  c_hogood: cover property ($rose(st_reg.hoGood));
  c_lor: cover property ($rose(referenceLostFlag));
  c_pbo_alarm: cover property ($rose(st_reg.pboLong));
endmodule : tms_supervisor

// ===== testbench/tms_host_model.sv
/*
  host control model: drives the two mode select pins and the two scaled-down
  8 kHz references. assumes the supervisor clock and reset are shared.
*/
`timescale 1ns/10ps
module tms_host_model import tms_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [1:0] reqMode,
  input wire logic refEn1,
  input wire logic refEn2,
  output logic modeSelectLow,
  output logic modeSelectHigh,
  output logic refIn1,
  output logic refIn2
);
  logic [1:0] divCnt;
  // pins follow the request just after the edge, both low while in reset
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {modeSelectHigh, modeSelectLow} <= 2'b00;
      divCnt <= 2'h0;
    end else begin
      {modeSelectHigh, modeSelectLow} <= reqMode;
      divCnt <= divCnt + 2'h1;
    end
  end
  // a dropped reference sits low like a dead line, so loss is seen once the timeout runs out
  assign refIn1 = refEn1 & divCnt[1];
  assign refIn2 = refEn2 & divCnt[1];
endmodule : tms_host_model

// ===== testbench/tb_top.sv
/*
  self-checking bench of the timing mode supervisor with shortened timers.
  assumes the host model for pins and references; bus reads go through a queue.
*/
`timescale 1ns/10ps
module tb_top import tms_pkg::*; ;
  localparam int TCYC = 20;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, triState, syncTick, syncRun;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rnd;
  logic signed [31:0] phaseErrNs, freqMeasPpb, freqSteerPpb;
  logic [1:0] reqMode, modeStatus;
  logic refEn1, refEn2, modeSelectLow, modeSelectHigh, refIn1, refIn2;
  logic referenceLostFlag, phaseBuildoutFlag, frequencyLimitAlarm, holdoverGood;
  logic modeAlarm, out8k, outEnN, out8kLast;
  logic [31:0] expQ[$];
  int mismatches = 0;
  int testsRun = 0;
  int cycles = 0;
  int edges8k = 0;

  tms_supervisor #(.TICK_CYC(TCYC), .LOR_CYC(8), .PBO_WIN_CYC(10), .PBO_ALARM_CYC(40)) DUT (
    .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .modeSelectLow(modeSelectLow), .modeSelectHigh(modeSelectHigh),
    .triState(triState), .refIn1(refIn1), .refIn2(refIn2), .phaseErrNs(phaseErrNs),
    .freqMeasPpb(freqMeasPpb), .syncTick(syncTick), .modeStatus(modeStatus),
    .referenceLostFlag(referenceLostFlag), .phaseBuildoutFlag(phaseBuildoutFlag),
    .frequencyLimitAlarm(frequencyLimitAlarm), .holdoverGood(holdoverGood),
    .modeAlarm(modeAlarm), .out8k(out8k), .freqSteerPpb(freqSteerPpb), .outEnN(outEnN));

  tms_host_model hostModel (.clk(clk), .rstn(rstn), .reqMode(reqMode), .refEn1(refEn1),
    .refEn2(refEn2), .modeSelectLow(modeSelectLow), .modeSelectHigh(modeSelectHigh),
    .refIn1(refIn1), .refIn2(refIn2));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one classic cycle; held until ack is sampled, then one idle cycle
  task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                        input logic [31:0] exp);
    int n;
    if (!we)
      expQ.push_back(exp);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    // a slave that never answers counts as a mismatch
    if (wb_ack_o !== 1'b1)
      mismatches++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask : wbXfer

  // ask the host for a mode and wait a bounded time for the status pins
  task automatic setMode(input logic [1:0] m);
    int n;
    reqMode <= m;
    for (n = 0; n < 20 && modeStatus !== m; n++)
      @(posedge clk);
    check("modeStatus", 32'(modeStatus), 32'(m));
  endtask : setMode

  // hang guard, sized well above the long holdover wait
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      finish_test();
    end
  end

  // read data is checked against the oldest note; divider edges counted
  always @(posedge clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expQ.size() > 0)
      check("wb_dat_o", wb_dat_o, expQ.pop_front());
    out8kLast <= out8k;
    if (out8k !== out8kLast)
      edges8k++;
    syncTick <= syncRun & ~syncTick;
  end

  initial begin
    int n;
    void'($urandom(32'hcd9811fd));
    {wb_cyc_i, wb_stb_i, wb_we_i, triState, syncTick, syncRun} = 6'h00;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    phaseErrNs = 32'sd0;
    freqMeasPpb = 32'sd0;
    reqMode = 2'b00;
    refEn1 = 1'b1;
    refEn2 = 1'b1;
    rnd = {16'h0, 16'($urandom)};
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    check("modeStatus", 32'(modeStatus), 32'h0);
    check("modeAlarm", 32'(modeAlarm), 32'h1);
    check("freqSteerPpb", freqSteerPpb, 32'h0);
    wbXfer(1'b0, CTRL_OFFS, 32'h0, {16'h0, DIV_RATIO_RST});
    wbXfer(1'b1, CTRL_OFFS, rnd, 32'h0);
    wbXfer(1'b0, CTRL_OFFS, 32'h0, rnd);
    wbXfer(1'b0, 8'h40, 32'h0, 32'h0);
    // ratio 4 with a tick every second cycle toggles out8k every 4 cycles
    wbXfer(1'b1, CTRL_OFFS, 32'h4, 32'h0);
    syncRun <= 1'b1;
    repeat (8) @(posedge clk);
    edges8k = 0;
    repeat (80) @(posedge clk);
    check("out8kEdges", 32'(edges8k >= 19 && edges8k <= 21), 32'h1);
    syncRun <= 1'b0;
    triState <= 1'b1;
    repeat (8) @(posedge clk);
    check("outEnN", 32'(outEnN), 32'h1);
    triState <= 1'b0;
    repeat (8) @(posedge clk);
    check("outEnN", 32'(outEnN), 32'h0);
    // far-off reference: steering slews up and trips the limit alarm
    freqMeasPpb <= 32'sd20000;
    setMode(TMS_REF1);
    check("modeAlarm", 32'(modeAlarm), 32'h1);
    repeat (2 * TCYC) @(posedge clk);
    check("freqLimit", 32'(frequencyLimitAlarm), 32'h0);
    repeat (10 * TCYC) @(posedge clk);
    check("freqLimit", 32'(frequencyLimitAlarm), 32'h1);
    setMode(TMS_HOLD);
    repeat (4) @(posedge clk);
    check("freqSteerPpb", freqSteerPpb, 32'h0);
    freqMeasPpb <= 32'($urandom_range(2000)) - 32'd1000;
    setMode(TMS_REF2);
    repeat (700 * TCYC) @(posedge clk);
    check("holdoverGood", 32'(holdoverGood), 32'h0);
    for (n = 0; n < 400 && holdoverGood !== 1'b1; n++)
      @(posedge clk);
    check("holdoverGood", 32'(holdoverGood), 32'h1);
    check("modeAlarm", 32'(modeAlarm), 32'h0);
    refEn2 <= 1'b0;
    for (n = 0; n < 40 && referenceLostFlag !== 1'b1; n++)
      @(posedge clk);
    check("refLost", 32'(referenceLostFlag), 32'h1);
    refEn2 <= 1'b1;
    for (n = 0; n < 40 && referenceLostFlag !== 1'b0; n++)
      @(posedge clk);
    check("refLost", 32'(referenceLostFlag), 32'h0);
    // phase jumps in every window keep the build-out flag up
    for (n = 0; n < 100; n++) begin
      phaseErrNs <= n[2] ? 32'sd5000 : 32'sd0;
      @(posedge clk);
      if (n == 24) begin
        check("buildout", 32'(phaseBuildoutFlag), 32'h1);
        check("modeAlarm", 32'(modeAlarm), 32'h0);
      end
    end
    check("modeAlarm", 32'(modeAlarm), 32'h1);
    phaseErrNs <= 32'sd0;
    repeat (40) @(posedge clk);
    check("buildout", 32'(phaseBuildoutFlag), 32'h0);
    check("modeAlarm", 32'(modeAlarm), 32'h0);
    // large phase error while locked restarts fast acquisition
    phaseErrNs <= 32'sd25000;
    repeat (3) @(posedge clk);
    phaseErrNs <= 32'sd0;
    for (n = 0; n < 10 && modeAlarm !== 1'b1; n++)
      @(posedge clk);
    check("modeAlarm", 32'(modeAlarm), 32'h1);
    setMode(TMS_REF1);
    check("holdoverGood", 32'(holdoverGood), 32'h0);
    // mid-run reset: mode, alarm and divider ratio all return to reset values
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    check("modeStatus", 32'(modeStatus), 32'h0);
    check("modeAlarm", 32'(modeAlarm), 32'h1);
    rstn <= 1'b1;
    wbXfer(1'b0, CTRL_OFFS, 32'h0, {16'h0, DIV_RATIO_RST});
    finish_test();
  end
endmodule : tb_top
